// ==== hdl/dcif_pkg.sv ====
package dcif_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned DEPTH = 8;
  localparam int unsigned PTR_W = 3;
  localparam int unsigned SAMPLE_W = 32;
  localparam int unsigned BUS_W = 16;
  localparam int unsigned DIV_W = 6;

  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SAMPLE = 8'h08;
  localparam logic [7:0] REG_SIF_SYNC = 8'h0c;

  // control register fields
  localparam int unsigned CTRL_WORD_BIT = 0;
  localparam int unsigned CTRL_OFFSET_LSB = 4;
  localparam int unsigned CTRL_FIFOIN_LSB = 8;
  localparam int unsigned CTRL_FIFOOUT_LSB = 12;
  localparam int unsigned CTRL_INTERP_LSB = 16;
  localparam int unsigned INTERP_W = 5;

  // sync select bit positions, shared by both select fields except SEL_OUTPUT_STROBE, read select only
  localparam int unsigned SEL_SYNC = 0;
  localparam int unsigned SEL_FRAME = 1;
  localparam int unsigned SEL_OUTPUT_STROBE = 2;
  localparam int unsigned SEL_SIF = 3;

  // status register fields
  localparam int unsigned STAT_WPTR_LSB = 0;
  localparam int unsigned STAT_RPTR_LSB = 4;
  localparam int unsigned STAT_COLL_BIT = 8;

  // reset values: word mode, offset 4, frame on both sides, interpolation 4
  localparam logic [31:0] CTRL_RST = 32'h0004_2241;
  localparam logic [2:0] WPTR_RST = 3'h0;
  localparam logic [1:0] PHASE_NARROW_LAST = 2'h3;
  localparam logic [1:0] PHASE_WORD_LAST = 2'h1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== hdl/dcif_pin_sync.sv ====
`timescale 1ns/1ps
// three-stage pin synchroniser; a bit changes once stages two and three agree
module dcif_pin_sync #(
  parameter int unsigned W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  wire [W-1:0] agree = ~(s2_q ^ s3_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level <= (level & ~agree) | (s3_q & agree);
    end
  end
endmodule

// ==== hdl/dcif_top.sv ====
`timescale 1ns/1ps
// Function
// - word_mode_sel low: samples arrive as bytes on the low eight data pins.
// - narrow mode byte order: I high, I low, Q high, Q low.
// - narrow mode groups realign on a rising edge of the selected strobe.
// - elastic buffer of eight 32-bit I/Q samples between bus and converter sides.
// - bus values captured on both data clock edges; sample stored at write pointer.
// - one whole sample read per output clock from the read pointer location.
// - output clock is converter clock over 2*interp (word) or interp (narrow).
// - each write and each read advances its pointer by one.
// - pointer reset puts write pointer at 0, read pointer at offset.
// - read reset location is a 3-bit programmable offset, default 4.
// - a 4-bit field selects the write pointer reset strobe.
// - write strobe sampled on data clock rising edges; its rise resets pointer.
// - 4-bit read select; write strobe resampled on output clock when chosen.
// - read-side reset also restarts the output clock divider.
// - output_strobe sampled by converter clock resets read pointer when chosen in the read select.
// - pointers wrap automatically, so resets may be single or repeated.
// - word_mode_sel high: each 16-bit word is one channel value, I first.
module dcif_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic data_ddr_clk,
  input wire logic [15:0] data_bus,
  input wire logic frame_in,
  input wire logic sync_in,
  input wire logic converter_clk,
  input wire logic output_strobe,
  output logic [31:0] sample_out,
  output logic sample_strobe
);
  // pin capture: data bus and its clock share one synchroniser so they stay aligned
  logic [15:0] bus_lvl;
  logic ddr_lvl;
  logic frame_lvl;
  logic sync_lvl;
  logic conv_lvl;
  logic output_strobe_lvl;

  dcif_pin_sync #(.W(21)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({data_bus, data_ddr_clk, frame_in, sync_in, converter_clk, output_strobe}),
    .level({bus_lvl, ddr_lvl, frame_lvl, sync_lvl, conv_lvl, output_strobe_lvl})
  );

  // registers
  logic [31:0] ctrl_q;
  logic sif_q;
  logic [31:0] sample_q;
  logic strobe_q;

  wire word_mode_sel = ctrl_q[dcif_pkg::CTRL_WORD_BIT];
  wire [2:0] fifo_offset = ctrl_q[dcif_pkg::CTRL_OFFSET_LSB +: 3];
  wire [3:0] sel_in = ctrl_q[dcif_pkg::CTRL_FIFOIN_LSB +: 4];
  wire [3:0] sel_out = ctrl_q[dcif_pkg::CTRL_FIFOOUT_LSB +: 4];
  wire [4:0] interp = ctrl_q[dcif_pkg::CTRL_INTERP_LSB +: dcif_pkg::INTERP_W];

  // write side
  logic ddr_prev_q;
  logic wsync_prev_q;
  logic [1:0] phase_q;
  logic [7:0] i_hi_q;
  logic [15:0] i_word_q;
  logic [7:0] q_hi_q;
  logic [2:0] wr_ptr_q;
  logic [31:0] mem_q [dcif_pkg::DEPTH];

  wire ddr_rise = ddr_lvl & ~ddr_prev_q;
  wire ddr_fall = ~ddr_lvl & ddr_prev_q;
  wire ddr_edge = ddr_rise | ddr_fall;
  wire wsync_lvl = (sel_in[dcif_pkg::SEL_SYNC] & sync_lvl) | (sel_in[dcif_pkg::SEL_FRAME] & frame_lvl)
                 | (sel_in[dcif_pkg::SEL_SIF] & sif_q);
  // strobe seen only at rising data clock edges
  wire wsync_rise = ddr_rise & wsync_lvl & ~wsync_prev_q;
  // alignment edge restarts the byte count
  wire [1:0] ph_cur = wsync_rise ? 2'h0 : phase_q;
  wire [1:0] ph_last = word_mode_sel ? dcif_pkg::PHASE_WORD_LAST : dcif_pkg::PHASE_NARROW_LAST;
  // entry written when the group completes
  wire wr_en = ddr_edge & (ph_cur == ph_last);
  // assembly of I and Q from bytes or words
  wire [31:0] wr_word = word_mode_sel ? {i_word_q, bus_lvl} : {i_hi_q, i_word_q[7:0], q_hi_q, bus_lvl[7:0]};
  wire [2:0] wr_ptr_d = wsync_rise ? dcif_pkg::WPTR_RST : wr_ptr_q + 3'h1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ddr_prev_q <= 1'b0;
      wsync_prev_q <= 1'b0;
    end else begin
      ddr_prev_q <= ddr_lvl;
      if (ddr_rise) begin
        wsync_prev_q <= wsync_lvl;
      end
    end
  end

  // capture on both edges of the data clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= 2'h0;
      i_hi_q <= 8'h00;
      i_word_q <= 16'h0000;
      q_hi_q <= 8'h00;
    end else if (ddr_edge) begin
      phase_q <= (ph_cur == ph_last) ? 2'h0 : ph_cur + 2'h1;
      // narrow mode uses only the low byte lanes
      case (ph_cur)
        2'h0: begin
          if (word_mode_sel) begin
            i_word_q <= bus_lvl;
          end else begin
            i_hi_q <= bus_lvl[7:0];
          end
        end
        2'h1: i_word_q <= {8'h00, bus_lvl[7:0]};
        2'h2: q_hi_q <= bus_lvl[7:0];
        default: q_hi_q <= q_hi_q;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem_q[wr_ptr_q] <= wr_word;
    end
  end

  // write pointer steps and wraps; strobe rise sends it home
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_q <= dcif_pkg::WPTR_RST;
    end else if (wsync_rise | wr_en) begin
      wr_ptr_q <= wr_ptr_d;
    end
  end

  // read side: converter clock edges drive the output clock divider
  logic conv_prev_q;
  logic output_strobe_prev_q;
  logic rsync_prev_q;
  logic [5:0] div_cnt_q;
  logic [2:0] rd_ptr_q;

  wire conv_en = conv_lvl & ~conv_prev_q;
  wire [4:0] interp_eff = (interp == 5'h00) ? 5'h01 : interp;
  // divide by 2*interp in word mode, interp in narrow mode
  wire [5:0] div_max = word_mode_sel ? ({interp_eff, 1'b0} - 6'h01) : ({1'b0, interp_eff} - 6'h01);
  wire out_en = conv_en & (div_cnt_q == div_max);
  // write strobe recaptured only at output clock ticks
  wire rsync_lvl = (sel_out[dcif_pkg::SEL_SYNC] & sync_lvl) | (sel_out[dcif_pkg::SEL_FRAME] & frame_lvl)
                 | (sel_out[dcif_pkg::SEL_SIF] & sif_q);
  wire rsync_rise = out_en & rsync_lvl & ~rsync_prev_q;
  // output strobe sampled on converter clock
  wire output_strobe_rise = conv_en & sel_out[dcif_pkg::SEL_OUTPUT_STROBE] & output_strobe_lvl & ~output_strobe_prev_q;
  wire rd_reset = rsync_rise | output_strobe_rise;
  wire [31:0] rd_word = mem_q[rd_ptr_q];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_prev_q <= 1'b0;
      output_strobe_prev_q <= 1'b0;
      rsync_prev_q <= 1'b0;
    end else begin
      conv_prev_q <= conv_lvl;
      if (conv_en) begin
        output_strobe_prev_q <= output_strobe_lvl;
      end
      if (out_en) begin
        rsync_prev_q <= rsync_lvl;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_q <= 6'h00;
    end else if (rd_reset) begin
      div_cnt_q <= 6'h00;
    end else if (conv_en) begin
      div_cnt_q <= (div_cnt_q >= div_max) ? 6'h00 : div_cnt_q + 6'h01;
    end
  end

  // one read per output tick; reset loads the offset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // constant home: ctrl_q is itself still in reset here
      rd_ptr_q <= dcif_pkg::CTRL_RST[dcif_pkg::CTRL_OFFSET_LSB +: 3];
      sample_q <= 32'h0000_0000;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= out_en & ~rd_reset;
      if (rd_reset) begin
        rd_ptr_q <= fifo_offset;
      end else if (out_en) begin
        rd_ptr_q <= rd_ptr_q + 3'h1;
        sample_q <= rd_word;
      end
    end
  end

  assign sample_out = sample_q;
  assign sample_strobe = strobe_q;

  // AXI4-Lite slave; write address and data may arrive in either order
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  wire do_write = aw_got_q & w_got_q & ~bvalid_q;
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire wr_ctrl = awaddr_q == dcif_pkg::REG_CTRL;
  wire wr_sif = awaddr_q == dcif_pkg::REG_SIF_SYNC;
  wire w_ok = wr_ctrl | wr_sif;
  wire ar_hs = s_axi_arvalid & ~rvalid_q;
  wire [31:0] status_word = {23'h0, wr_ptr_q == rd_ptr_q, 1'b0, rd_ptr_q, 1'b0, wr_ptr_q};
  wire r_ctrl = s_axi_araddr == dcif_pkg::REG_CTRL;
  wire r_stat = s_axi_araddr == dcif_pkg::REG_STATUS;
  wire r_samp = s_axi_araddr == dcif_pkg::REG_SAMPLE;
  wire r_sif = s_axi_araddr == dcif_pkg::REG_SIF_SYNC;
  wire [31:0] rd_mux = r_ctrl ? ctrl_q : r_stat ? status_word : r_samp ? sample_q : r_sif ? {31'h0, sif_q} : 32'h0;

  assign s_axi_awready = ~aw_got_q & ~bvalid_q;
  assign s_axi_wready = ~w_got_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_got_q <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_got_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= dcif_pkg::CTRL_RST;
      sif_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= dcif_pkg::RESP_OKAY;
    end else begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= w_ok ? dcif_pkg::RESP_OKAY : dcif_pkg::RESP_SLVERR;
        if (wr_ctrl) begin
          ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask);
        end
        if (wr_sif & wstrb_q[0]) begin
          sif_q <= wdata_q[0];
        end
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= dcif_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= (r_ctrl | r_stat | r_samp | r_sif) ? dcif_pkg::RESP_OKAY : dcif_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_wptr_home: assert property (wsync_rise |=> wr_ptr_q == 3'h0)
    else $error("write pointer not home after strobe rise");
  chk_wptr_step: assert property (wr_en && !wsync_rise |=> wr_ptr_q == $past(wr_ptr_q) + 3'h1)
    else $error("write pointer did not advance by one");
  chk_sample_store: assert property (wr_en |=> mem_q[$past(wr_ptr_q)] == $past(wr_word))
    else $error("sample not stored at write pointer");
  chk_narrow_group: assert property (wr_en && !word_mode_sel |-> ph_cur == 2'h3)
    else $error("narrow write before fourth byte");
  chk_rptr_offset: assert property (rd_reset |=> rd_ptr_q == $past(fifo_offset))
    else $error("read pointer not at offset after reset");
  chk_rptr_step: assert property (out_en && !rd_reset |=> rd_ptr_q == $past(rd_ptr_q) + 3'h1)
    else $error("read pointer did not advance by one");
  chk_read_data: assert property (out_en && !rd_reset |=> sample_q == $past(rd_word) && sample_strobe)
    else $error("read sample mismatch");
  chk_div_restart: assert property (rd_reset |=> div_cnt_q == 6'h00)
    else $error("divider not restarted by read reset");
  chk_outclk_rate: assert property (out_en |-> div_cnt_q == div_max && conv_en)
    else $error("output tick off the divide count");
  chk_output_strobe_reset: assert property (output_strobe_rise |-> rd_reset ##1 rd_ptr_q == $past(fifo_offset))
    else $error("output strobe did not reset read pointer");
endmodule

// ==== testbench/dcif_src_model.sv ====
`timescale 1ns/1ps
module dcif_src_model (
  input wire logic aclk,
  input wire logic word_mode,
  input wire logic use_sync,
  output logic data_ddr_clk,
  output logic [15:0] data_bus,
  output logic frame_in,
  output logic sync_in
);
  initial begin
    data_ddr_clk = 1'b0;
    data_bus = 16'h0000;
    frame_in = 1'b0;
    sync_in = 1'b0;
  end
  // one value per clock edge, level held past the four-cycle pin path
  task automatic put(input logic [15:0] v, input logic mark);
    @(posedge aclk);
    data_bus <= v;
    data_ddr_clk <= ~data_ddr_clk;
    // strobe rise rides the first value, once per burst
    if (!data_ddr_clk) begin
      sync_in <= mark & use_sync;
      frame_in <= mark & ~use_sync;
    end
    repeat (5) @(posedge aclk);
  endtask
  // I then Q words, or four bytes msb first on the low lane
  task automatic send(input logic [31:0] s, input logic first);
    if (word_mode) begin
      put(s[31:16], first);
      put(s[15:0], 1'b0);
    end else begin
      for (int i = 0; i < 4; i++) begin
        put({~s[31-8*i -: 8], s[31-8*i -: 8]}, first && i == 0);
      end
    end
    // clock parked low between samples; bus must not look stable
    @(posedge aclk);
    data_bus <= ~data_bus;
  endtask
  // half a byte group, to knock the grouping out of step
  task automatic half();
    put(16'h5aa5, 1'b0);
    put(16'ha55a, 1'b0);
  endtask
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, sample_strobe;
  logic converter_clk, output_strobe, word_mode, use_sync, ddr_clk, frame_in, sync_in;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, sample_out;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] data_bus;
  int failures, samples_checked, cedges;
  logic [31:0] got_q[$];
  int at_q[$];

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  dcif_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .data_ddr_clk(ddr_clk),
    .data_bus(data_bus), .frame_in(frame_in), .sync_in(sync_in), .converter_clk(converter_clk),
    .output_strobe(output_strobe), .sample_out(sample_out), .sample_strobe(sample_strobe));

  dcif_src_model src_u (.aclk(aclk), .word_mode(word_mode), .use_sync(use_sync),
    .data_ddr_clk(ddr_clk), .data_bus(data_bus), .frame_in(frame_in), .sync_in(sync_in));

  // sampled mid-cycle so the pulse and its data are settled
  always @(negedge aclk) begin
    if (sample_strobe === 1'b1) begin
      got_q.push_back(sample_out);
      at_q.push_back(cedges);
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic hang(input int n);
    if (n > 200) begin
      failures++;
      $display("Error %0t handshake timeout", $time);
      report_and_stop();
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t resp got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    int n;
    n = 0;
    b_t = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = awvalid && awready === 1'b1;
      w_t = wvalid && wready === 1'b1;
      b_t = bvalid === 1'b1;
      r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
      n++;
      hang(n);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    int n;
    n = 0;
    r_t = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t) begin
      @(negedge aclk);
      ar_t = arvalid && arready === 1'b1;
      r_t = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
      n++;
      hang(n);
    end
  endtask

  // strobe moves in the low phase so the next rising edge sees it cleanly
  task automatic conv(input int n, input logic os);
    repeat (n) begin
      @(posedge aclk);
      converter_clk <= 1'b1;
      cedges++;
      repeat (4) @(posedge aclk);
      converter_clk <= 1'b0;
      output_strobe <= os;
      repeat (3) @(posedge aclk);
    end
  endtask

  initial begin
    logic [31:0] d;
    logic [31:0] exp_s[8];
    logic [1:0] r;
    int off, ip, dv;
    failures = 0;
    samples_checked = 0;
    cedges = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {converter_clk, output_strobe, word_mode, use_sync} = 4'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    void'($urandom(60600));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(dcif_pkg::REG_CTRL, d, r);
    chk_word(d, dcif_pkg::CTRL_RST, "ctrl reset");
    rd(dcif_pkg::REG_STATUS, d, r);
    chk_word(d, 32'h0000_0040, "ptr reset");
    rd(8'h10, d, r);
    chk_resp(r, dcif_pkg::RESP_SLVERR);
    chk_word(d, 32'h0, "unmapped");
    wr(8'h10, 32'hffff_ffff, r);
    chk_resp(r, dcif_pkg::RESP_SLVERR);
    for (int t = 0; t < 4; t++) begin
      word_mode <= t[0];
      use_sync <= t[1];
      ip = 1 + $urandom % 3;
      off = $urandom % 8;
      dv = t[0] ? 2 * ip : ip;
      wr(dcif_pkg::REG_CTRL, {11'h0, 5'(ip), 4'h4, t[1] ? 4'h1 : 4'h2, 1'b0, 3'(off), 3'h0, 1'(t[0])}, r);
      chk_resp(r, dcif_pkg::RESP_OKAY);
      // stray data first, so the sync rise has something to undo
      for (int k = 0; k < 3; k++) src_u.send($urandom, 1'b0);
      if (!t[0]) src_u.half();
      // read side idle while filling, so nothing is read until all eight are written
      for (int k = 0; k < 8; k++) begin
        exp_s[k] = $urandom;
        src_u.send(exp_s[k], k == 0);
      end
      rd(dcif_pkg::REG_STATUS, d, r);
      chk_word(d & 32'h7, 32'h0, "wr ptr wrap");
      conv(1, 1'b1);
      got_q.delete();
      at_q.delete();
      conv(9 * dv, 1'b0);
      chk_word(32'(got_q.size() > 7), 32'h1, "read count");
      for (int k = 0; k < 8 && k < got_q.size(); k++) begin
        chk_word(got_q[k], exp_s[(off + k) % 8], "sample");
        if (k > 0) chk_word(32'(at_q[k] - at_q[k-1]), 32'(dv), "out rate");
      end
      rd(dcif_pkg::REG_SAMPLE, d, r);
      chk_word(d, exp_s[(off + 7) % 8], "sample reg");
    end
    // software sync on the read side: its rise is taken at the next output tick
    off = $urandom % 8;
    wr(dcif_pkg::REG_CTRL, {11'h0, 5'(ip), 4'h8, 4'h1, 1'b0, 3'(off), 3'h0, 1'b1}, r);
    chk_resp(r, dcif_pkg::RESP_OKAY);
    wr(dcif_pkg::REG_SIF_SYNC, 32'h0000_0001, r);
    chk_resp(r, dcif_pkg::RESP_OKAY);
    got_q.delete();
    conv(dv, 1'b0);
    rd(dcif_pkg::REG_STATUS, d, r);
    chk_word((d >> 4) & 32'h7, 32'(off), "rd ptr sif sync");
    chk_word(32'(got_q.size()), 32'h0, "read on reset tick");
    conv(dv, 1'b0);
    chk_word(32'(got_q.size()), 32'h1, "reads after sif sync");
    if (got_q.size() > 0) chk_word(got_q[0], exp_s[off], "first after sif sync");
    report_and_stop();
  end
endmodule
